// file: hw/sds_pkg.sv
// constants for the 40-bit serial datagram slave
// assumes a 10 MHz system clock and a serial clock of at most a quarter of it
`default_nettype none
package sds_pkg;
	localparam int DGRAM_BITS = 40;
	localparam int CNT_W = 6;
	localparam logic [5:0] FULL_COUNT = 6'h28;
	localparam int WR_BIT = 39;
	localparam int ADDR_HI = 38;
	localparam int ADDR_LO = 32;
	localparam int DATA_HI = 31;
	// reply status byte layout
	localparam int ST_RSVD = 7;
	localparam int ST_STOP2 = 6;
	localparam int ST_STOP1 = 5;
	localparam int ST_VEL2 = 4;
	localparam int ST_VEL1 = 3;
	localparam int ST_ERR2 = 2;
	localparam int ST_ERR1 = 1;
	localparam int ST_RST = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;
	// input filter: pulses shorter than this are dropped
	localparam int CLK_NS = 100;
	localparam int FILT_NS = 20;
	localparam int FILT_CYC_RAW = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
	localparam int PIN_COUNT = 4;
	localparam int PIN_SCK = 0;
	localparam int PIN_SDI = 1;
	localparam int PIN_SEL = 2;
	localparam int PIN_DIS = 3;
	localparam logic [3:0] PIN_IDLE = 4'hD;
	typedef enum logic [1:0] {
		SDS_IDLE = 2'h0,
		SDS_FRAME = 2'h1,
		SDS_FETCH = 2'h3
	} sds_state_t;
endpackage
`default_nettype wire

// file: hw/sds_pin_if.sv
// filtered pin levels passed from the input conditioner to the slave core
// assumes both ends sit on the system clock
`default_nettype none
interface sds_pin_if;
	logic [3:0] level;
	modport conditioner (output level);
	modport core (input level);
endinterface
`default_nettype wire

// file: hw/sds_in_filter.sv
// input conditioner: two-flop synchroniser then an agreement filter per pin
// assumes raw pins are asynchronous to clk_in
`default_nettype none
module sds_in_filter (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [3:0] pins_in,
	sds_pin_if.conditioner pins
);
	genvar gi;
	generate
		for (gi = 0; gi < sds_pkg::PIN_COUNT; gi++) begin : g_pin
			logic meta;
			logic sync;
			logic [sds_pkg::FILT_CYC-1:0] hist;
			logic [sds_pkg::FILT_CYC:0] hist_shifted;
			logic level;
			// oldest sample falls off the top of the history
			assign hist_shifted = {hist, sync};
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					meta <= sds_pkg::PIN_IDLE[gi];
					sync <= sds_pkg::PIN_IDLE[gi];
				end else begin
					meta <= pins_in[gi];
					sync <= meta;
				end
			end
			// glitch filter
			// a level must persist past the filter span before it is taken
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					hist <= {sds_pkg::FILT_CYC{sds_pkg::PIN_IDLE[gi]}};
					level <= sds_pkg::PIN_IDLE[gi];
				end else begin
					hist <= hist_shifted[sds_pkg::FILT_CYC-1:0];
					if (hist == {sds_pkg::FILT_CYC{sync}}) begin
						level <= sync;
					end
				end
			end
			assign pins.level[gi] = level;
		end
	endgenerate
endmodule
`default_nettype wire

// file: hw/sds_slave.sv
// 40-bit serial datagram slave, mode 3, with pipelined read back
// assumes an outside register file that answers cmd_addr_out on rd_data_in
// within one clock, and flag sources on the system clock
//
// Contract
// - datagram is address byte plus 32 data
// - bit 39 set means write
// - reply shifted out on every datagram
// - after a read, reply carries that register
// - after a write, reply echoes write data
// - read data bits are never stored; cmd_data_out still latches them on a read
// - reply bits 39..32 carry status byte
// - status bit layout, bit 7 zero
// - error and reset bits mirror global flags
// - status latched at end of access
// - data right aligned, two's complement
// - active only while select low
// - sample on rise, drive after fall
// - extra bits emerge forty clocks later
// - select rise executes last 40 bits
// - inputs ignore pulses under 20 ns
`default_nettype none
module sds_slave (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sck_in,
	input wire logic sdi_in,
	input wire logic select_low_in,
	input wire logic output_disable_input_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	output logic output_disable_out,
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output logic [6:0] cmd_addr_out,
	output logic [31:0] cmd_data_out,
	input wire logic [31:0] rd_data_in,
	input wire logic [1:0] stop_left_in,
	input wire logic [1:0] velocity_reached_in,
	input wire logic [1:0] driver_error_in,
	input wire logic reset_flag_in
);
	// ************************************************
	// input conditioning
	// ************************************************
	sds_pin_if pins ();

	sds_in_filter u_filter (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pins_in({output_disable_input_in, select_low_in, sdi_in, sck_in}),
		.pins(pins.conditioner)
	);

	logic sck;
	logic sdi;
	logic sel_low;
	logic sck_prev;
	logic sel_prev;
	logic sck_rise;
	logic sck_fall;
	logic frame_start;
	logic frame_end;

	assign sck = pins.level[sds_pkg::PIN_SCK];
	assign sdi = pins.level[sds_pkg::PIN_SDI];
	assign sel_low = pins.level[sds_pkg::PIN_SEL];

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sck_prev <= 1'b1;
			sel_prev <= 1'b1;
		end else begin
			sck_prev <= sck;
			sel_prev <= sel_low;
		end
	end

	assign frame_start = sel_prev & ~sel_low;
	assign frame_end = ~sel_prev & sel_low;
	assign sck_rise = ~sel_low & ~sck_prev & sck;
	assign sck_fall = ~sel_low & sck_prev & ~sck;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			output_disable_out <= 1'b0;
		end else begin
			output_disable_out <= pins.level[sds_pkg::PIN_DIS];
		end
	end

	// ************************************************
	// frame sequencing
	// ************************************************
	sds_pkg::sds_state_t state;
	logic [39:0] shift;
	logic [sds_pkg::CNT_W-1:0] count;
	logic [7:0] status;
	logic [31:0] reply_data;
	logic execute;

	// partial frames
	// fewer than forty clocks means nothing is executed
	assign execute = frame_end && (count == sds_pkg::FULL_COUNT);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= sds_pkg::SDS_IDLE;
		end else begin
			case (state)
				sds_pkg::SDS_IDLE: begin
					if (frame_start) begin
						state <= sds_pkg::SDS_FRAME;
					end
				end
				sds_pkg::SDS_FRAME: begin
					if (execute && !shift[sds_pkg::WR_BIT]) begin
						state <= sds_pkg::SDS_FETCH;
					end else if (frame_end) begin
						state <= sds_pkg::SDS_IDLE;
					end
				end
				sds_pkg::SDS_FETCH: begin
					state <= sds_pkg::SDS_IDLE;
				end
				default: begin
					state <= sds_pkg::SDS_IDLE;
				end
			endcase
		end
	end

	// overrun bits leave forty clocks later
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			shift <= {8'h00, sds_pkg::DATA_RESET};
			count <= '0;
		end else if (frame_start) begin
			shift <= {status, reply_data};
			count <= '0;
		end else if (sck_rise) begin
			shift <= {shift[38:0], sdi};
			if (count != sds_pkg::FULL_COUNT) begin
				count <= count + 6'h01;
			end
		end
	end

	// msb first after falling edge
	// first bit is presented as soon as select falls
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sdo_out <= 1'b0;
			sdo_oe_out <= 1'b0;
		end else begin
			sdo_oe_out <= ~sel_low;
			if (frame_start) begin
				sdo_out <= status[7];
			end else if (sck_fall) begin
				sdo_out <= shift[39];
			end
		end
	end

	// ************************************************
	// command execution
	// ************************************************
	// latch on select rise
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_valid_out <= 1'b0;
			cmd_write_out <= 1'b0;
			cmd_addr_out <= '0;
			cmd_data_out <= sds_pkg::DATA_RESET;
		end else begin
			cmd_valid_out <= execute;
			if (execute) begin
				cmd_write_out <= shift[sds_pkg::WR_BIT];
				cmd_addr_out <= shift[sds_pkg::ADDR_HI:sds_pkg::ADDR_LO];
				cmd_data_out <= shift[sds_pkg::DATA_HI:0];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reply_data <= sds_pkg::DATA_RESET;
		end else if (execute && shift[sds_pkg::WR_BIT]) begin
			reply_data <= shift[sds_pkg::DATA_HI:0];
		end else if (state == sds_pkg::SDS_FETCH) begin
			reply_data <= rd_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			status <= sds_pkg::STATUS_RESET;
		end else if (frame_end) begin
			status[sds_pkg::ST_RSVD] <= 1'b0;
			status[sds_pkg::ST_STOP2] <= stop_left_in[1];
			status[sds_pkg::ST_STOP1] <= stop_left_in[0];
			status[sds_pkg::ST_VEL2] <= velocity_reached_in[1];
			status[sds_pkg::ST_VEL1] <= velocity_reached_in[0];
			status[sds_pkg::ST_ERR2] <= driver_error_in[1];
			status[sds_pkg::ST_ERR1] <= driver_error_in[0];
			status[sds_pkg::ST_RST] <= reset_flag_in;
		end
	end
endmodule
`default_nettype wire

// file: verification/sds_slave_chk.sv
// port checker for the serial datagram slave
// assumes binding to sds_slave, one clock domain
`default_nettype none
module sds_slave_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic select_low_in,
	input wire logic output_disable_input_in,
	input wire logic sdo_out,
	input wire logic sdo_oe_out,
	input wire logic output_disable_out,
	input wire logic cmd_valid_out,
	input wire logic cmd_write_out,
	input wire logic [6:0] cmd_addr_out,
	input wire logic [31:0] cmd_data_out
);
	// ****
	// properties
	// ****
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_sel_idle;
		select_low_in [*8];
	endsequence
	sequence s_sel_open;
		$fell(select_low_in);
	endsequence
	property p_pulse;
		cmd_valid_out |=> !cmd_valid_out;
	endproperty
	a_pulse: assert property (p_pulse) else $error("cmd pulse long");
	property p_hold;
		!cmd_valid_out |-> $stable({cmd_write_out, cmd_addr_out, cmd_data_out});
	endproperty
	a_hold: assert property (p_hold) else $error("cmd moved");
	// executes only after a frame that has closed
	property p_exec;
		cmd_valid_out |-> $past(select_low_in, 3) && $past(sdo_oe_out, 3);
	endproperty
	a_exec: assert property (p_exec) else $error("stray cmd");
	property p_idle;
		s_sel_idle |-> !sdo_oe_out;
	endproperty
	a_idle: assert property (p_idle) else $error("drives unselected");
	property p_open;
		s_sel_open |-> ##[3:7] sdo_oe_out;
	endproperty
	a_open: assert property (p_open) else $error("no reply drive");
	property p_first;
		$rose(sdo_oe_out) |-> !sdo_out;
	endproperty
	a_first: assert property (p_first) else $error("status bit7 set");
	property p_dis_hi;
		output_disable_input_in [*6] |-> output_disable_out;
	endproperty
	a_dis_hi: assert property (p_dis_hi) else $error("disable lost");
	property p_dis_lo;
		!output_disable_input_in [*6] |-> !output_disable_out;
	endproperty
	a_dis_lo: assert property (p_dis_lo) else $error("disable stuck");
endmodule
bind sds_slave sds_slave_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
	.select_low_in(select_low_in), .sdo_out(sdo_out),
	.output_disable_input_in(output_disable_input_in),
	.sdo_oe_out(sdo_oe_out), .output_disable_out(output_disable_out),
	.cmd_valid_out(cmd_valid_out), .cmd_write_out(cmd_write_out),
	.cmd_addr_out(cmd_addr_out), .cmd_data_out(cmd_data_out));
`default_nettype wire

// file: verification/sds_host_model.sv
// host master model sending mode 3 frames
// assumes the slave resamples pins on a 10 MHz clock
`default_nettype none
module sds_host_model (
	input wire logic clk_in,
	input wire logic sdo_in,
	input wire logic sdo_oe_in,
	output var logic sck_out,
	output var logic sdi_out,
	output var logic select_low_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sck_out = 1'b1;
		sdi_out = 1'b0;
		select_low_out = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// select low whole frame, 800 ns clock
	task automatic xfer(input int n, input logic [79:0] d,
		output logic [79:0] q);
		q = 80'h0;
		select_low_out = 1'b0;
		tick(8);
		for (int i = n - 1; i >= 0; i--) begin
			sck_out = 1'b0;
			sdi_out = d[i];
			tick(4);
			sck_out = 1'b1;
			tick(4);
			// the slave output trails the fall by several clocks, so
			// the bit is taken at the end of its cell, before the next fall
			q = {q[78:0], sdo_oe_in ? sdo_in : 1'bx};
		end
		select_low_out = 1'b1;
		sdi_out = ~sdi_out;
		tick(8);
	endtask
endmodule
`default_nettype wire

// file: verification/sds_slave_test.sv
// self-checking bench for the serial datagram slave
// assumes the host model and a bench register file
`default_nettype none
module sds_slave_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in, rst_in, sck, sdi, sel, dis, sdo, oe, dis_o, cv, cw, rf;
	logic [6:0] ca;
	logic [31:0] cd, rd;
	logic [1:0] stop, vel, err;
	logic [7:0] s;
	logic [79:0] q;
	int bad_count, compares, n_cmd, c;
	sds_slave uut (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck),
		.sdi_in(sdi), .select_low_in(sel), .output_disable_input_in(dis),
		.sdo_out(sdo), .sdo_oe_out(oe), .output_disable_out(dis_o),
		.cmd_valid_out(cv), .cmd_write_out(cw), .cmd_addr_out(ca),
		.cmd_data_out(cd), .rd_data_in(rd), .stop_left_in(stop),
		.velocity_reached_in(vel), .driver_error_in(err),
		.reset_flag_in(rf));
	sds_host_model host (.clk_in(clk_in), .sdo_in(sdo), .sdo_oe_in(oe),
		.sck_out(sck), .sdi_out(sdi), .select_low_out(sel));
	// ****
	// clock, register file, helpers
	// ****
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	function automatic logic [31:0] regf(input logic [6:0] a);
		return {4{1'b0, a}};
	endfunction
	function automatic logic [7:0] st();
		return {1'b0, stop, vel, err, rf};
	endfunction
	always @(posedge clk_in) begin
		#1;
		rd = regf(ca);
		if (cv === 1'b1) n_cmd++;
	end
	task automatic chk(input string nm, input logic [39:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_read;
		{stop, vel, err, rf} = 7'h4F;
		host.xfer(40, {8'h21, 32'hFFFF_FFFF}, q);
		chk("reply0", 40'h0, q[39:0]);
		s = st();
		{stop, vel, err, rf} = 7'h28;
		host.xfer(40, {8'h15, 32'h0}, q);
		chk("reply1", {s, regf(7'h21)}, q[39:0]);
		chk("rd_cmd", {1'b0, 7'h15, 32'h0}, {cw, ca, cd});
		$display("t_read done");
	endtask
	task automatic t_write;
		s = st();
		host.xfer(40, {8'h80 + 8'h22, 32'hDEAD_BEEF}, q);
		chk("reply2", {s, regf(7'h15)}, q[39:0]);
		chk("cmd", {1'b1, 7'h22, 32'hDEAD_BEEF}, {cw, ca, cd});
		s = st();
		host.xfer(40, {8'h80 + 8'h05, 32'h0000_0001}, q);
		chk("reply3", {s, 32'hDEAD_BEEF}, q[39:0]);
		$display("t_write done");
	endtask
	task automatic t_short;
		c = n_cmd;
		s = st();
		host.xfer(20, {60'h0, 20'hABCDE}, q);
		chk("short_reply", {20'h0, s, 12'h000}, q[39:0]);
		chk("short_cmds", 40'h0, 40'(n_cmd - c));
		host.xfer(40, {8'h30, 32'h0}, q);
		chk("after_short", {s, 32'h0000_0001}, q[39:0]);
		$display("t_short done");
	endtask
	task automatic t_long;
		s = st();
		host.xfer(48, {32'h0, 8'hA5, 8'h80 + 8'h10, 32'h1234_5678}, q);
		chk("reply_long", {s, regf(7'h30)}, q[47:8]);
		chk("chain", 40'hA5, {32'h0, q[7:0]});
		chk("last40", {1'b1, 7'h10, 32'h1234_5678}, {cw, ca, cd});
		$display("t_long done");
	endtask
	task automatic t_dis;
		dis = 1'b0;
		host.tick(8);
		#20 dis = 1'b1;
		#10 dis = 1'b0;
		host.tick(8);
		chk("dis_glitch", 40'h0, {39'h0, dis_o});
		dis = 1'b1;
		host.tick(8);
		chk("dis_follow", 40'h1, {39'h0, dis_o});
		$display("t_dis done");
	endtask
	initial begin
		{rst_in, dis, stop, vel, err, rf} = {2'h3, 7'h00};
		repeat (4) @(posedge clk_in);
		#1 rst_in = 1'b0;
		host.tick(8);
		t_read();
		t_write();
		t_short();
		t_long();
		t_dis();
		close_out();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk_in);
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire
